//--- tm16_pkg.sv
// Purpose: shared constants and types of the 16-bit timer/event counter
// Assumes: one clock, no register bus, settings arrive as plain ports
// Notes:   mode and edge encodings follow the two-bit control fields
package tm16_pkg;

	// Counter mode field encodings (hi, lo)
	localparam logic [1:0] MODE_STOP      = 2'h0;
	localparam logic [1:0] MODE_FREE      = 2'h1;
	localparam logic [1:0] MODE_EDGE_CLR  = 2'h2;
	localparam logic [1:0] MODE_MATCH_CLR = 2'h3;

	// Valid edge field encodings (hi, lo)
	localparam logic [1:0] EDGE_FALL      = 2'h0;
	localparam logic [1:0] EDGE_RISE      = 2'h1;
	localparam logic [1:0] EDGE_BOTH      = 2'h3;

	// Counter values
	localparam logic [15:0] CNT_RESET     = 16'h0000;
	localparam logic [15:0] CNT_MAX       = 16'hFFFF;
	localparam logic [15:0] CNT_ONE       = 16'h0001;

	// Prescaler width and divide masks for /1, /4, /16, /64
	localparam int          PRE_W         = 6;
	localparam logic [5:0]  PRE_RESET     = 6'h00;
	localparam logic [5:0]  PRE_ONE       = 6'h01;
	localparam logic [5:0]  PRE_MASK_1    = 6'h00;
	localparam logic [5:0]  PRE_MASK_4    = 6'h03;
	localparam logic [5:0]  PRE_MASK_16   = 6'h0F;
	localparam logic [5:0]  PRE_MASK_64   = 6'h3F;

	// Static configuration carried as one bundle
	typedef struct packed {
		logic       counter_mode_hi_bit;  // Mode field, upper bit
		logic       counter_mode_lo_bit;  // Mode field, lower bit
		logic       edge_select_hi_bit;   // Valid edge, upper bit
		logic       edge_select_lo_bit;   // Valid edge, lower bit
		logic       output_enable_bit;    // Drive the wave output
		logic       toggle_on_match_bit;  // Invert on primary match
		logic       oneshot_mode_bit;     // One-shot pulse operation
		logic       count_src_ext_bit;    // Count valid input edges
		logic [1:0] prescale_edge_cfg;    // Count clock divide select
	} tm16_cfg_t;

	// One-shot pulse sequencer states
	typedef enum logic [1:0] {
		OS_IDLE,
		OS_WAIT,
		OS_ACTIVE
	} tm16_os_state_t;

endpackage

//--- tm16_timer.sv
// Purpose: 16-bit timer/event counter with square wave and one-shot output
// Assumes: settings are stable while counting; compares written when stopped
// Notes:   edges seen by the filter drive counting, triggers and restarts
`timescale 1ns/100ps

module tm16_timer
	import tm16_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Configuration
	input  wire tm16_cfg_t   cfg,
	input  wire logic [15:0] primary_compare_reg,
	input  wire logic [15:0] secondary_compare_reg,
	// Software strobes, one cycle each
	input  wire logic        soft_pulse_trigger_bit,
	input  wire logic        wrap_flag_clear,
	// External pin
	input  wire logic        ext_event_input,
	// Status and outputs
	output logic [15:0]      count_value_reg,
	output logic             wrap_flag,
	output logic             primary_match_irq,
	output logic             secondary_match_irq,
	output logic             wave_output_pin
);

	// Valid edge decision for the selected field
	function automatic logic edge_ok(input logic [1:0] sel,
		input logic rise, input logic fall);
		logic ok;
		if (sel == EDGE_RISE) begin
			ok = rise;
		end else if (sel == EDGE_FALL) begin
			ok = fall;
		end else begin
			ok = rise | fall;
		end
		return ok;
	endfunction

	// Divide mask for the prescaler select
	function automatic logic [5:0] pre_mask(input logic [1:0] sel);
		logic [5:0] m;
		case (sel)
			2'h0: m = PRE_MASK_1;
			2'h1: m = PRE_MASK_4;
			2'h2: m = PRE_MASK_16;
			default: m = PRE_MASK_64;
		endcase
		return m;
	endfunction

	// Decoded fields
	logic [1:0]     mode;          // Counter mode field
	logic [1:0]     edge_sel;      // Valid edge field
	logic           running;       // Counter enabled
	// Input synchroniser and filter
	logic           sync1_q;       // First stage, read by stage two only
	logic           sync2_q;       // Second stage
	logic           samp_q;        // Previous synchronised sample
	logic           filt_q;        // Accepted input level
	logic           rise;          // Accepted rising edge
	logic           fall;          // Accepted falling edge
	logic           valid_edge;    // Selected edge while running
	// Count clock
	logic [PRE_W-1:0] pre_q;       // Free prescaler
	logic           pre_tick_q;    // Prescaled count clock pulse
	logic           tick;          // Count event this cycle
	// Counter
	logic [15:0]    cnt_q;
	logic [15:0]    cnt_d;
	logic           pri_hit;       // Count equals primary compare
	logic           sec_hit;       // Count equals secondary compare
	logic           trig;          // Clear-and-start request
	logic           wrap_ev;       // Counter passes maximum
	// One-shot
	tm16_os_state_t os_q;
	logic           on_hit;        // Match that makes the pulse active
	logic           off_hit;       // Match that ends the pulse
	logic           wave_q;
	assign mode     = {cfg.counter_mode_hi_bit, cfg.counter_mode_lo_bit};
	assign edge_sel = {cfg.edge_select_hi_bit, cfg.edge_select_lo_bit};
	assign running  = (mode != MODE_STOP);
	// Two-flop synchroniser for the pin
	always_ff @(posedge clock) begin
		if (reset) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= ext_event_input;
			sync2_q <= sync1_q;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			samp_q <= 1'b0;
			filt_q <= 1'b0;
		end else begin
			samp_q <= sync2_q;
			if (sync2_q == samp_q) begin
				filt_q <= sync2_q;
			end
		end
	end

	// Filtered edges, ignored while stopped
	assign rise = (sync2_q == samp_q) & sync2_q & ~filt_q;
	assign fall = (sync2_q == samp_q) & ~sync2_q & filt_q;
	assign valid_edge = running & edge_ok(edge_sel, rise, fall);
	// Free prescaler; start is not aligned to it
	always_ff @(posedge clock) begin
		if (reset) begin
			pre_q      <= PRE_RESET;
			pre_tick_q <= 1'b0;
		end else begin
			pre_q      <= pre_q + PRE_ONE;
			pre_tick_q <= ((pre_q & pre_mask(cfg.prescale_edge_cfg))
				== pre_mask(cfg.prescale_edge_cfg));
		end
	end

	assign tick = running & (cfg.count_src_ext_bit ? valid_edge
		: pre_tick_q);
	assign pri_hit = (cnt_q == primary_compare_reg);
	assign sec_hit = (cnt_q == secondary_compare_reg);
	assign trig = running & ~cfg.count_src_ext_bit &
		((cfg.oneshot_mode_bit & soft_pulse_trigger_bit) |
		(valid_edge & (cfg.oneshot_mode_bit | (mode == MODE_EDGE_CLR))));
	assign wrap_ev = tick & ~trig & (cnt_q == CNT_MAX) &
		((mode != MODE_MATCH_CLR) | (primary_compare_reg == CNT_MAX));
	// Next count value
	always_comb begin
		cnt_d = cnt_q;
		if (!running) begin
			cnt_d = CNT_RESET;
		end else if (trig) begin
			cnt_d = CNT_RESET;
		end else if (tick) begin
			if ((mode == MODE_MATCH_CLR) && pri_hit) begin
				cnt_d = CNT_RESET;
			end else begin
				cnt_d = cnt_q + CNT_ONE;
			end
		end
	end

	// Counter register
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_q <= CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Visible count and match requests
	always_ff @(posedge clock) begin
		if (reset) begin
			count_value_reg     <= CNT_RESET;
			primary_match_irq   <= 1'b0;
			secondary_match_irq <= 1'b0;
		end else begin
			count_value_reg     <= cnt_d;
			primary_match_irq   <= tick & ~trig & pri_hit;
			secondary_match_irq <= tick & ~trig & sec_hit;
		end
	end

	// Sticky wrap flag, a set beats a clear
	always_ff @(posedge clock) begin
		if (reset) begin
			wrap_flag <= 1'b0;
		end else if (wrap_ev) begin
			wrap_flag <= 1'b1;
		end else if (wrap_flag_clear) begin
			wrap_flag <= 1'b0;
		end
	end

	assign on_hit  = tick & ~trig & ((secondary_compare_reg <
		primary_compare_reg) ? sec_hit : pri_hit);
	assign off_hit = tick & ~trig & ((secondary_compare_reg <
		primary_compare_reg) ? pri_hit : sec_hit);
	// One-shot sequencer
	always_ff @(posedge clock) begin
		if (reset) begin
			os_q <= OS_IDLE;
		end else if (!running || !cfg.oneshot_mode_bit) begin
			os_q <= OS_IDLE;
		end else if (trig) begin
			os_q <= OS_WAIT;
		end else begin
			case (os_q)
				OS_WAIT: if (on_hit) begin
					os_q <= OS_ACTIVE;
				end
				OS_ACTIVE: if (off_hit) begin
					os_q <= OS_IDLE;
				end
				default: os_q <= OS_IDLE;
			endcase
		end
	end

	// Output flip-flop
	always_ff @(posedge clock) begin
		if (reset) begin
			wave_q <= 1'b0;
		end else if (!running || !cfg.output_enable_bit) begin
			wave_q <= 1'b0;
		end else if (cfg.oneshot_mode_bit) begin
			// Active from on to off match
			if (os_q == OS_WAIT && !trig && on_hit) begin
				wave_q <= 1'b1;
			end else if (os_q == OS_ACTIVE && !trig && off_hit) begin
				wave_q <= 1'b0;
			end else if (os_q == OS_IDLE) begin
				wave_q <= 1'b0;
			end
		end else if (cfg.toggle_on_match_bit && tick && pri_hit) begin
			wave_q <= ~wave_q;
		end
	end

	assign wave_output_pin = wave_q;
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	sequence s_pri_tick;
		tick && !trig && pri_hit;
	endsequence
	sequence s_wait_on;
		cfg.oneshot_mode_bit && cfg.output_enable_bit && running &&
			os_q == OS_WAIT && on_hit && !trig;
	endsequence
	property p_match_clear;
		(mode == MODE_MATCH_CLR) and s_pri_tick |=>
			cnt_q == CNT_RESET && primary_match_irq;
	endproperty
	a_match_clear: assert property (p_match_clear)
		else $error("counter not cleared on primary match");
	property p_wrap;
		!wrap_flag ##1 wrap_flag |->
			$past(cnt_q) == CNT_MAX && count_value_reg == CNT_RESET;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("wrap flag set without passing maximum");
	property p_toggle;
		running && cfg.output_enable_bit && cfg.toggle_on_match_bit &&
			!cfg.oneshot_mode_bit and s_pri_tick |=>
			wave_output_pin != $past(wave_output_pin);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("square wave did not invert on match");
	property p_trig_clear;
		trig |=> cnt_q == CNT_RESET ##1 os_q == OS_WAIT ||
			!cfg.oneshot_mode_bit || trig || !running;
	endproperty
	a_trig_clear: assert property (p_trig_clear)
		else $error("trigger did not clear and start");
	property p_on_edge;
		s_wait_on |=> wave_output_pin && os_q == OS_ACTIVE;
	endproperty
	a_on_edge: assert property (p_on_edge)
		else $error("pulse did not go active on first match");
	property p_keep;
		running && (mode == MODE_FREE) && tick && !trig |=>
			cnt_q == $past(cnt_q) + CNT_ONE;
	endproperty
	a_keep: assert property (p_keep)
		else $error("free counter did not advance");
	property p_ext_trig;
		running && cfg.oneshot_mode_bit && !cfg.count_src_ext_bit &&
			valid_edge |=> cnt_q == CNT_RESET;
	endproperty
	a_ext_trig: assert property (p_ext_trig)
		else $error("input edge did not restart one-shot");
	property p_stop;
		!running |=> cnt_q == CNT_RESET && !wave_output_pin;
	endproperty
	a_stop: assert property (p_stop)
		else $error("counter not held while stopped");
	property p_filter;
		!filt_q ##1 filt_q |-> $past(sync2_q) && $past(samp_q);
	endproperty
	a_filter: assert property (p_filter)
		else $error("edge accepted after one sample");
	property p_idle_low;
		cfg.oneshot_mode_bit && os_q == OS_IDLE ##1
			cfg.oneshot_mode_bit && os_q == OS_IDLE |-> !wave_output_pin;
	endproperty
	a_idle_low: assert property (p_idle_low)
		else $error("one-shot output active before trigger");
endmodule

//--- tm16_pin_src.sv
// Purpose: model of the external pulse source on the event input pin
// Assumes: pin is driven at all times, changes after a falling edge
// Notes:   watches the wave pin so that no trigger lands inside a pulse
`timescale 1ns/100ps

module tm16_pin_src (
	// Clock
	input  wire logic clock,
	// Pins
	input  wire logic wave_output_pin,
	output logic      ext_event_input
);
	// Pin rests low
	initial ext_event_input = 1'b0;

	// Settle the pin at a level for a number of cycles
	task automatic drive(input logic lv, input int hold);
		int i;
		for (i = 0; i < 400 && wave_output_pin === 1'b1; i++)
			@(negedge clock);
		@(negedge clock);
		ext_event_input = lv;
		repeat (hold) @(negedge clock);
	endtask

	// One-cycle noise pulse, too short for the filter
	task automatic spike();
		@(negedge clock);
		ext_event_input = ~ext_event_input;
		@(negedge clock);
		ext_event_input = ~ext_event_input;
		repeat (8) @(negedge clock);
	endtask
endmodule

//--- timer16_event_square_oneshot_test.sv
// Purpose: self-checking bench of the 16-bit timer/event counter
// Assumes: inputs change at the falling edge, outputs read there
// Notes:   monitor times gaps between wave pin changes against notes
`timescale 1ns/100ps

module timer16_event_square_oneshot_test;
	import tm16_pkg::*;
	logic        clock, reset, soft_pulse_trigger_bit, wrap_flag_clear;
	tm16_cfg_t   cfg;                 // Static settings
	logic [15:0] primary_compare_reg;
	logic [15:0] secondary_compare_reg;
	logic        ext_event_input, wrap_flag, wave_output_pin, wave_prev;
	logic        primary_match_irq, secondary_match_irq;
	logic [15:0] count_value_reg, c;
	int          fail_count, n_checks, gap, n_edges, n_irq, e, lv, hit;
	int          notes[$];            // Expected gaps, 0 means unchecked
	int          m, p, want, n_sec, k;

	// Device and far-side pin model
	tm16_timer DUT (.clock(clock), .reset(reset), .cfg(cfg),
		.primary_compare_reg(primary_compare_reg),
		.secondary_compare_reg(secondary_compare_reg),
		.soft_pulse_trigger_bit(soft_pulse_trigger_bit),
		.wrap_flag_clear(wrap_flag_clear),
		.ext_event_input(ext_event_input),
		.count_value_reg(count_value_reg), .wrap_flag(wrap_flag),
		.primary_match_irq(primary_match_irq),
		.secondary_match_irq(secondary_match_irq),
		.wave_output_pin(wave_output_pin));
	tm16_pin_src src (.clock(clock), .wave_output_pin(wave_output_pin),
		.ext_event_input(ext_event_input));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and stop
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Monitor: gap since the last wave change, against oldest note
	always @(negedge clock) begin
		gap++;
		if (primary_match_irq === 1'b1)
			n_irq++;
		if (secondary_match_irq === 1'b1)
			n_sec++;
		if (wave_output_pin !== wave_prev) begin
			n_edges++;
			if (notes.size() > 0) begin
				want = notes.pop_front();
				if (want != 0) chk(16'(gap), 16'(want));
			end
			gap = 0;
		end
		wave_prev = wave_output_pin;
	end

	// Settings with the mode stopped; mode is written last by go
	task automatic setcfg(input logic [1:0] ed, input logic oe, tog, os,
		ext, input logic [1:0] pre, input logic [15:0] pm, sm);
		@(negedge clock);
		cfg = {2'h0, ed, oe, tog, os, ext, pre};
		primary_compare_reg = pm;
		secondary_compare_reg = sm;
	endtask

	task automatic go(input logic [1:0] md);
		@(negedge clock);
		{cfg.counter_mode_hi_bit, cfg.counter_mode_lo_bit} = md;
	endtask

	// Wait for all notes to be consumed, bounded
	task automatic drain(input int lim);
		int i;
		for (i = 0; i < lim && notes.size() > 0; i++) @(negedge clock);
		chk(16'(notes.size()), 16'h0000);
		notes.delete();
	endtask

	task automatic oneshot(input logic [15:0] n, input logic [15:0] mm);
		setcfg(EDGE_RISE, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, mm, n);
		go(MODE_FREE);
		repeat (8) @(negedge clock);
		chk(16'(wave_output_pin), 16'h0000);
		notes.push_back(0);
		notes.push_back((n < mm) ? mm - n : n - mm);
		soft_pulse_trigger_bit = 1'b1;
		n_sec = 0;
		@(negedge clock);
		soft_pulse_trigger_bit = 1'b0;
		drain(200);
		c = count_value_reg;
		repeat (10) @(negedge clock);
		chk(count_value_reg, c + 16'h000A);
		chk(16'(n_sec), 16'h0001);
		go(MODE_STOP);
	endtask

	// Watchdog
	initial begin
		#950000;
		fail_count++;
		end_of_test();
	end

	// Main sequence
	initial begin
		reset = 1'b1;
		cfg = '0;
		primary_compare_reg = 16'h0001;
		secondary_compare_reg = 16'h0001;
		soft_pulse_trigger_bit = 1'b0;
		wrap_flag_clear = 1'b0;
		void'($urandom(21440));
		repeat (6) @(negedge clock);
		reset = 1'b0;
		setcfg(EDGE_RISE, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 16'h0003, 16'h0009);
		go(MODE_MATCH_CLR);
		for (e = 1; e <= 8; e++) begin
			src.drive(1'b1, 6);
			src.drive(1'b0, 6);
			chk(count_value_reg, 16'(e % 4));
		end
		chk(16'(n_irq), 16'h0002);
		src.spike();
		chk(count_value_reg, 16'h0000);
		chk(16'(wrap_flag), 16'h0000);
		go(MODE_STOP);
		// clear on input edge, count restarts at zero
		setcfg(EDGE_RISE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'hFFFF, 16'h0001);
		go(MODE_EDGE_CLR);
		repeat (20) @(negedge clock);
		src.drive(1'b1, 6);
		chk(count_value_reg, 16'h0002);
		src.drive(1'b0, 6);
		go(MODE_STOP);
		// square wave, compare fixed while running
		for (p = 0; p < 4; p++) begin
			m = 1 + $urandom % 5;
			setcfg(EDGE_RISE, 1'b1, 1'b1, 1'b0, 1'b0, 2'(p), 16'(m), 16'h0);
			go(MODE_MATCH_CLR);
			notes.push_back(0);
			repeat (4) notes.push_back((m + 1) * (1 << (2 * p)));
			drain(3000);
			go(MODE_STOP);
		end
		oneshot(16'h0003, 16'h0007);
		oneshot(16'h0009, 16'h0004);
		for (k = 0; k < 3; k++) begin
			e = (k == 0) ? 0 : (k == 1) ? 1 : 3;
			setcfg(2'(e), 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 16'h0005, 16'h0002);
			go(MODE_FREE);
			for (lv = 1; lv >= 0; lv--) begin
				hit = (e == 3) || (e % 2 == lv);
				c = 16'(n_edges);
				if (hit) begin
					notes.push_back(0);
					notes.push_back(3);
				end
				src.drive(lv[0], 40);
				drain(100);
				if (!hit) chk(16'(n_edges) - c, 16'h0000);
			end
			go(MODE_STOP);
		end
		setcfg(EDGE_RISE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'hFFFF, 16'h1);
		go(MODE_MATCH_CLR);
		for (e = 0; e < 70000 && wrap_flag !== 1'b1; e++) @(negedge clock);
		chk(count_value_reg, 16'h0000);
		repeat (3) @(negedge clock);
		wrap_flag_clear = 1'b1;
		@(negedge clock);
		wrap_flag_clear = 1'b0;
		@(negedge clock);
		chk(16'(wrap_flag), 16'h0000);
		end_of_test();
	end
endmodule
